// File: rtl/sbss_pkg.sv
// constants, codes and types of the status bit source select parameter bank
// ****************************************************************************
// ****************************************************************************
package sbss_pkg;
    // parameter addresses on the fieldbus
    localparam logic [15:0] ADDR_STATE_TRANSITION_MODE_CFG = 16'h1B26;
    localparam logic [15:0] ADDR_STATUS_WORD_LIMIT_SOURCE = 16'h1B3C;
    localparam logic [15:0] ADDR_PROFILE_MODE_CONTROL = 16'h1B3E;
    localparam logic [15:0] ADDR_PROFILE_REFERENCE_B = 16'h1B42;
    localparam logic [15:0] ADDR_PROFILE_REFERENCE_A = 16'h1B44;
    localparam logic [15:0] ADDR_MOTION_STATUS_LIMIT_SOURCE = 16'h1B6A;
    // selector code set
    localparam int SRC_W = 4;
    localparam logic [3:0] SRC_NONE = 4'h0;
    localparam logic [3:0] SRC_MAX = 4'hB;
    localparam logic [3:0] SRC_RESET = 4'h0;
    localparam int COND_N = 11;
    // transition mode codes
    localparam logic MODE_AUTOMATIC = 1'b0;
    localparam logic MODE_COMMANDED = 1'b1;
    localparam logic MODE_RESET = 1'b0;
    // reset values of the profile parameters
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] REF_A_RESET = 16'h0000;
    localparam logic [31:0] REF_B_RESET = 32'h0000_0000;
    // displayed state numbers
    localparam logic [3:0] STATE_NUM_INHIBIT = 4'h3;
    localparam logic [3:0] STATE_NUM_ARMED = 4'h4;
    // drive state machine, one-hot
    typedef enum logic [1:0] {
        ST_POWER_INHIBIT = 2'b01,
        ST_ARMED = 2'b10
    } sbss_state_e;
endpackage

// File: rtl/sbss_cond_sel.sv
// condition multiplexer for one internal-limit status bit
`timescale 1ns/10ps
module sbss_cond_sel (
    input wire logic [3:0] sel_code,
    input wire logic [10:0] cond_vec,
    output logic sel_bit
);
    // ************************************************************************
    // selection
    // ************************************************************************
    // code n picks cond_vec[n-1]; code 0 and codes past the set read 0
    always_comb begin
        sel_bit = 1'b0;
        if (sel_code != sbss_pkg::SRC_NONE && sel_code <= sbss_pkg::SRC_MAX) begin
            sel_bit = cond_vec[sel_code - 4'h1];
        end
    end
endmodule // sbss_cond_sel

// File: rtl/sbss_top.sv
// parameter bank selecting internal-limit status sources and the 3-to-4 transition mode
`timescale 1ns/10ps
module sbss_top (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic param_wr,
    input wire logic param_rd,
    input wire logic [15:0] param_addr,
    input wire logic [31:0] param_wdata,
    input wire logic [1:0] param_channel,
    output logic [31:0] param_rdata,
    output logic param_ack,
    output logic param_err,
    input wire logic profile_active,
    input wire logic [1:0] profile_channel,
    input wire logic power_stage_enabled,
    input wire logic cmd_shutdown,
    input wire logic cmd_disable_voltage,
    input wire logic nv_restore,
    input wire logic [3:0] nv_motion_src,
    input wire logic [3:0] nv_status_src,
    input wire logic nv_mode,
    output logic nv_save,
    input wire logic current_below_thr,
    input wire logic velocity_below_thr,
    input wire logic in_position_dev_win,
    input wire logic in_velocity_dev_win,
    input wire logic pos_reg_ch1,
    input wire logic pos_reg_ch2,
    input wire logic pos_reg_ch3,
    input wire logic pos_reg_ch4,
    input wire logic hw_limit_switch,
    input wire logic relative_move_after_capture,
    input wire logic position_window,
    output logic action_status_limit,
    output logic motion_status_limit,
    output logic status_word_limit,
    output logic [3:0] drive_state,
    output logic [15:0] profile_mode_control,
    output logic [15:0] profile_reference_a,
    output logic [31:0] profile_reference_b
);
    // ************************************************************************
    // helpers
    // ************************************************************************
    // one range check shared by both selectors and the restore path
    function automatic logic src_valid(input logic [31:0] v);
        src_valid = (v <= {28'h0000000, sbss_pkg::SRC_MAX});
    endfunction

    function automatic logic is_profile_addr(input logic [15:0] a);
        is_profile_addr = (a == sbss_pkg::ADDR_PROFILE_MODE_CONTROL) ||
                          (a == sbss_pkg::ADDR_PROFILE_REFERENCE_A) ||
                          (a == sbss_pkg::ADDR_PROFILE_REFERENCE_B);
    endfunction

    // ************************************************************************
    // state
    // ************************************************************************
    logic [3:0] motion_src_reg;
    logic [3:0] motion_src_next;
    logic [3:0] status_src_reg;
    logic [3:0] status_src_next;
    logic mode_reg;
    logic mode_next;
    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_next;
    logic [15:0] ref_a_reg;
    logic [15:0] ref_a_next;
    logic [31:0] ref_b_reg;
    logic [31:0] ref_b_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic ack_reg;
    logic ack_next;
    logic err_reg;
    logic err_next;
    logic save_reg;
    logic save_next;
    sbss_pkg::sbss_state_e state_reg;
    sbss_pkg::sbss_state_e state_next;
    logic [3:0] state_num_reg;
    logic [3:0] state_num_next;
    logic act_lim_reg;
    logic mot_lim_reg;
    logic sw_lim_reg;
    logic mot_sel;
    logic sw_sel;
    logic [10:0] cond_vec;
    logic chan_refused;

    // profile owner check: only while the profile is active does the owner matter
    assign chan_refused = profile_active && (param_channel != profile_channel);

    // ************************************************************************
    // parameter access
    // ************************************************************************
    // one request per cycle, answered by ack or err on the next edge; a request in a cycle with nv_restore high gets neither
    always_comb begin
        motion_src_next = motion_src_reg;
        status_src_next = status_src_reg;
        mode_next = mode_reg;
        ctrl_next = ctrl_reg;
        ref_a_next = ref_a_reg;
        ref_b_next = ref_b_reg;
        rdata_next = rdata_reg;
        ack_next = 1'b0;
        err_next = 1'b0;
        save_next = 1'b0;
        if (nv_restore) begin
            // invalid stored values fall back to defaults rather than poison the bits
            motion_src_next = src_valid({28'h0000000, nv_motion_src}) ? nv_motion_src :
                              sbss_pkg::SRC_RESET;
            status_src_next = src_valid({28'h0000000, nv_status_src}) ? nv_status_src :
                              sbss_pkg::SRC_RESET;
            mode_next = nv_mode;
        end else if (param_wr) begin
            ack_next = 1'b1;
            if (is_profile_addr(param_addr) && chan_refused) begin
                ack_next = 1'b0;
                err_next = 1'b1;
            end else begin
                case (param_addr)
                    sbss_pkg::ADDR_MOTION_STATUS_LIMIT_SOURCE: begin
                        if (src_valid(param_wdata)) begin
                            motion_src_next = param_wdata[3:0];
                            save_next = 1'b1;
                        end else begin
                            ack_next = 1'b0;
                            err_next = 1'b1;
                        end
                    end
                    sbss_pkg::ADDR_STATUS_WORD_LIMIT_SOURCE: begin
                        if (src_valid(param_wdata)) begin
                            status_src_next = param_wdata[3:0];
                            save_next = 1'b1;
                        end else begin
                            ack_next = 1'b0;
                            err_next = 1'b1;
                        end
                    end
                    sbss_pkg::ADDR_STATE_TRANSITION_MODE_CFG: begin
                        // a live power stage must not see its transition policy change
                        if (!power_stage_enabled && param_wdata[31:1] == 31'h00000000) begin
                            mode_next = param_wdata[0];
                            save_next = 1'b1;
                        end else begin
                            ack_next = 1'b0;
                            err_next = 1'b1;
                        end
                    end
                    sbss_pkg::ADDR_PROFILE_MODE_CONTROL: begin
                        ctrl_next = param_wdata[15:0];
                    end
                    sbss_pkg::ADDR_PROFILE_REFERENCE_A: begin
                        ref_a_next = param_wdata[15:0];
                    end
                    sbss_pkg::ADDR_PROFILE_REFERENCE_B: begin
                        ref_b_next = param_wdata;
                    end
                    default: begin
                        ack_next = 1'b0;
                        err_next = 1'b1;
                    end
                endcase
            end
        end else if (param_rd) begin
            ack_next = 1'b1;
            rdata_next = 32'h0000_0000;
            if (is_profile_addr(param_addr) && chan_refused) begin
                ack_next = 1'b0;
                err_next = 1'b1;
            end else begin
                case (param_addr)
                    sbss_pkg::ADDR_MOTION_STATUS_LIMIT_SOURCE: begin
                        rdata_next = {28'h0000000, motion_src_reg};
                    end
                    sbss_pkg::ADDR_STATUS_WORD_LIMIT_SOURCE: begin
                        rdata_next = {28'h0000000, status_src_reg};
                    end
                    sbss_pkg::ADDR_STATE_TRANSITION_MODE_CFG: begin
                        rdata_next = {31'h00000000, mode_reg};
                    end
                    sbss_pkg::ADDR_PROFILE_MODE_CONTROL: begin
                        rdata_next = {16'h0000, ctrl_reg};
                    end
                    sbss_pkg::ADDR_PROFILE_REFERENCE_A: begin
                        rdata_next = {16'h0000, ref_a_reg};
                    end
                    sbss_pkg::ADDR_PROFILE_REFERENCE_B: begin
                        rdata_next = ref_b_reg;
                    end
                    default: begin
                        ack_next = 1'b0;
                        err_next = 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            motion_src_reg <= sbss_pkg::SRC_RESET;
            status_src_reg <= sbss_pkg::SRC_RESET;
            mode_reg <= sbss_pkg::MODE_RESET;
            ctrl_reg <= sbss_pkg::CTRL_RESET;
            ref_a_reg <= sbss_pkg::REF_A_RESET;
            ref_b_reg <= sbss_pkg::REF_B_RESET;
            rdata_reg <= 32'h0000_0000;
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
            save_reg <= 1'b0;
        end else begin
            motion_src_reg <= motion_src_next;
            status_src_reg <= status_src_next;
            mode_reg <= mode_next;
            ctrl_reg <= ctrl_next;
            ref_a_reg <= ref_a_next;
            ref_b_reg <= ref_b_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
            err_reg <= err_next;
            save_reg <= save_next;
        end
    end

    // ************************************************************************
    // transition from state 3 to state 4
    // ************************************************************************
    // disable voltage wins over an arming request in the same cycle
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            sbss_pkg::ST_POWER_INHIBIT: begin
                if (!cmd_disable_voltage &&
                    (mode_reg == sbss_pkg::MODE_AUTOMATIC || cmd_shutdown)) begin
                    state_next = sbss_pkg::ST_ARMED;
                end
            end
            sbss_pkg::ST_ARMED: begin
                if (cmd_disable_voltage) begin
                    state_next = sbss_pkg::ST_POWER_INHIBIT;
                end
            end
            default: begin
                state_next = sbss_pkg::ST_POWER_INHIBIT;
            end
        endcase
        state_num_next = (state_next == sbss_pkg::ST_ARMED) ? sbss_pkg::STATE_NUM_ARMED :
                         sbss_pkg::STATE_NUM_INHIBIT;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= sbss_pkg::ST_POWER_INHIBIT;
            state_num_reg <= sbss_pkg::STATE_NUM_INHIBIT;
        end else begin
            state_reg <= state_next;
            state_num_reg <= state_num_next;
        end
    end

    // ************************************************************************
    // status bit sources
    // ************************************************************************
    // condition order matches codes 1 to 11
    assign cond_vec = {position_window, relative_move_after_capture, hw_limit_switch,
                       pos_reg_ch4, pos_reg_ch3, pos_reg_ch2, pos_reg_ch1,
                       in_velocity_dev_win, in_position_dev_win,
                       velocity_below_thr, current_below_thr};

    sbss_cond_sel u_motion_sel (
        .sel_code(motion_src_reg),
        .cond_vec(cond_vec),
        .sel_bit(mot_sel)
    );

    sbss_cond_sel u_status_sel (
        .sel_code(status_src_reg),
        .cond_vec(cond_vec),
        .sel_bit(sw_sel)
    );

    // one register stage so the outputs are flop driven; costs a cycle of latency
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            act_lim_reg <= 1'b0;
            mot_lim_reg <= 1'b0;
            sw_lim_reg <= 1'b0;
        end else begin
            act_lim_reg <= mot_sel;
            mot_lim_reg <= mot_sel;
            sw_lim_reg <= sw_sel;
        end
    end

    // ************************************************************************
    // outputs
    // ************************************************************************
    assign param_rdata = rdata_reg;
    assign param_ack = ack_reg;
    assign param_err = err_reg;
    assign nv_save = save_reg;
    assign action_status_limit = act_lim_reg;
    assign motion_status_limit = mot_lim_reg;
    assign status_word_limit = sw_lim_reg;
    assign drive_state = state_num_reg;
    assign profile_mode_control = ctrl_reg;
    assign profile_reference_a = ref_a_reg;
    assign profile_reference_b = ref_b_reg;

    // ************************************************************************
    // checks
    // ************************************************************************
    bits_agree_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        act_lim_reg == mot_lim_reg) else $error("status bit 9 copies differ");
    chan_pick_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (motion_src_reg == 4'h5) |=> (mot_lim_reg == $past(pos_reg_ch1)))
        else $error("code 5 not following channel 1");
    reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (status_src_reg == sbss_pkg::SRC_NONE) |=> !sw_lim_reg)
        else $error("reserved code drives status bit 11");
    sel_range_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (param_wr && !nv_restore && param_addr == sbss_pkg::ADDR_MOTION_STATUS_LIMIT_SOURCE
         && param_wdata > 32'h0000_000B) |=> (err_reg && $stable(motion_src_reg)))
        else $error("out of range selector accepted");
    sel_instant_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (param_wr && !nv_restore && !chan_refused && param_wdata == 32'h0000_0009 &&
         param_addr == sbss_pkg::ADDR_MOTION_STATUS_LIMIT_SOURCE && hw_limit_switch)
        ##1 hw_limit_switch |=> mot_lim_reg) else $error("selector change not immediate");
    auto_arm_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state_reg == sbss_pkg::ST_POWER_INHIBIT && mode_reg == sbss_pkg::MODE_AUTOMATIC &&
         !cmd_disable_voltage) |=> (drive_state == sbss_pkg::STATE_NUM_ARMED))
        else $error("automatic transition missing");
    hold_inhibit_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state_reg == sbss_pkg::ST_POWER_INHIBIT && mode_reg == sbss_pkg::MODE_COMMANDED &&
         !cmd_shutdown) |=> (state_reg == sbss_pkg::ST_POWER_INHIBIT))
        else $error("left state 3 without command");
    mode_lock_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (param_wr && !nv_restore && power_stage_enabled &&
         param_addr == sbss_pkg::ADDR_STATE_TRANSITION_MODE_CFG)
        |=> (err_reg && !ack_reg && $stable(mode_reg))) else $error("mode changed while enabled");
    chan_refuse_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (param_wr && !nv_restore && chan_refused &&
         param_addr == sbss_pkg::ADDR_PROFILE_REFERENCE_B)
        |=> (err_reg && $stable(ref_b_reg))) else $error("foreign channel wrote profile");
    ref_b_store_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (param_wr && !nv_restore && !chan_refused &&
         param_addr == sbss_pkg::ADDR_PROFILE_REFERENCE_B)
        |=> (ref_b_reg == $past(param_wdata) && ack_reg)) else $error("reference b not stored");
endmodule // sbss_top

// File: tb/sbss_master_model.sv
// fieldbus master model issuing single parameter reads and writes
`timescale 1ns/10ps
module sbss_master_model (
    input wire logic clk_sys,
    output logic param_wr,
    output logic param_rd,
    output logic [15:0] param_addr,
    output logic [31:0] param_wdata,
    output logic [1:0] param_channel,
    input wire logic [31:0] param_rdata,
    input wire logic param_ack,
    input wire logic param_err
);
    // idle bus at time zero
    initial begin
        param_wr = 1'b0;
        param_rd = 1'b0;
        param_addr = 16'h0000;
        param_wdata = 32'h0000_0000;
        param_channel = 2'h0;
    end

    // one-cycle request, answer sampled a cycle later; address and data are
    // inverted on release so a stale value never looks valid
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d,
        input logic [1:0] ch, output logic [31:0] rd, output logic [1:0] resp);
        @(negedge clk_sys);
        param_wr = wr;
        param_rd = ~wr;
        param_addr = a;
        param_wdata = d;
        param_channel = ch;
        @(negedge clk_sys);
        param_wr = 1'b0;
        param_rd = 1'b0;
        param_addr = ~a;
        param_wdata = ~d;
        resp = {param_err, param_ack};
        rd = param_rdata;
    endtask
endmodule // sbss_master_model

// File: tb/tb.sv
// self-checking bench for the status bit source select parameter bank
`timescale 1ns/10ps
module tb;
    localparam logic [15:0] MODE = 16'h1B26;
    localparam logic [15:0] STAT = 16'h1B3C;
    localparam logic [15:0] CTRL = 16'h1B3E;
    localparam logic [15:0] REFB = 16'h1B42;
    localparam logic [15:0] REFA = 16'h1B44;
    localparam logic [15:0] MOT = 16'h1B6A;
    localparam logic [15:0] ADDRS [6] = '{MODE, STAT, CTRL, REFB, REFA, MOT};
    localparam logic [1:0] OK = 2'h1;
    localparam logic [1:0] BAD = 2'h2;
    logic clk_sys, resetn, param_wr, param_rd, param_ack, param_err, nv_save, nv_mode;
    logic profile_active, power_stage_enabled, cmd_shutdown, cmd_disable_voltage, nv_restore;
    logic action_status_limit, motion_status_limit, status_word_limit;
    logic [1:0] param_channel, profile_channel, resp;
    logic [3:0] nv_motion_src, nv_status_src, drive_state;
    logic [10:0] cond;
    logic [15:0] param_addr, profile_mode_control, profile_reference_a;
    logic [31:0] param_wdata, param_rdata, profile_reference_b, rd, v;
    int n_fail, cmp_count;

    sbss_top i_sbss_top (.clk_sys(clk_sys), .resetn(resetn), .param_wr(param_wr),
        .param_rd(param_rd), .param_addr(param_addr), .param_wdata(param_wdata),
        .param_channel(param_channel), .param_rdata(param_rdata), .param_ack(param_ack),
        .param_err(param_err), .profile_active(profile_active),
        .profile_channel(profile_channel), .power_stage_enabled(power_stage_enabled),
        .cmd_shutdown(cmd_shutdown), .cmd_disable_voltage(cmd_disable_voltage),
        .nv_restore(nv_restore), .nv_motion_src(nv_motion_src),
        .nv_status_src(nv_status_src), .nv_mode(nv_mode), .nv_save(nv_save),
        .current_below_thr(cond[0]), .velocity_below_thr(cond[1]),
        .in_position_dev_win(cond[2]), .in_velocity_dev_win(cond[3]),
        .pos_reg_ch1(cond[4]), .pos_reg_ch2(cond[5]), .pos_reg_ch3(cond[6]),
        .pos_reg_ch4(cond[7]), .hw_limit_switch(cond[8]),
        .relative_move_after_capture(cond[9]), .position_window(cond[10]),
        .action_status_limit(action_status_limit), .motion_status_limit(motion_status_limit),
        .status_word_limit(status_word_limit), .drive_state(drive_state),
        .profile_mode_control(profile_mode_control),
        .profile_reference_a(profile_reference_a), .profile_reference_b(profile_reference_b));

    sbss_master_model i_sbss_master_model (.clk_sys(clk_sys), .param_wr(param_wr),
        .param_rd(param_rd), .param_addr(param_addr), .param_wdata(param_wdata),
        .param_channel(param_channel), .param_rdata(param_rdata),
        .param_ack(param_ack), .param_err(param_err));

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // code 0 and anything past 11 read as a constant 0
    function automatic logic exp_bit(input logic [3:0] code, input logic [10:0] c);
        return (code >= 4'h1 && code <= 4'hB) ? c[code - 4'h1] : 1'b0;
    endfunction

    task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] d,
        input logic [1:0] ch, input logic [1:0] exp_resp);
        i_sbss_master_model.xfer(wr, a, d, ch, rd, resp);
        check({30'h0, resp}, {30'h0, exp_resp});
    endtask

    task automatic end_of_test();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // free-running 25 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // watchdog against a hang
    initial begin
        #400000;
        n_fail++;
        end_of_test();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        {resetn, profile_active, power_stage_enabled, cmd_shutdown} = 4'h0;
        {cmd_disable_voltage, nv_restore, nv_mode} = 3'h0;
        {profile_channel, nv_motion_src, nv_status_src, cond} = 21'h0;
        n_fail = 0;
        cmp_count = 0;
        void'($urandom(7052));
        repeat (12) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (2) @(negedge clk_sys);
        check({28'h0, drive_state}, 32'h4);
        foreach (ADDRS[i]) begin
            acc(1'b0, ADDRS[i], 32'h0, 2'h0, OK);
            check(rd, 32'h0);
        end
        // both selectors swept through every code, random conditions
        for (int c = 0; c < 12; c++) begin
            acc(1'b1, MOT, c, 2'h1, OK);
            check({31'h0, nv_save}, 32'h1);
            acc(1'b1, STAT, 11 - c, 2'h2, OK);
            repeat (4) begin
                cond = 11'($urandom);
                @(negedge clk_sys);
                check({29'h0, action_status_limit, motion_status_limit, status_word_limit},
                    {29'h0, {2{exp_bit(c[3:0], cond)}}, exp_bit(4'(11 - c), cond)});
            end
        end
        acc(1'b1, MOT, 32'hC, 2'h0, BAD);
        acc(1'b1, MOT, $urandom_range(65535, 13), 2'h0, BAD);
        acc(1'b0, MOT, 32'h0, 2'h0, OK);
        check(rd, 32'hB);
        acc(1'b1, 16'h1B28, 32'h0, 2'h0, BAD);
        // mode changes only with the power stage off
        power_stage_enabled = 1'b1;
        acc(1'b1, MODE, 32'h1, 2'h0, BAD);
        power_stage_enabled = 1'b0;
        acc(1'b1, MODE, 32'h2, 2'h0, BAD);
        acc(1'b1, MODE, 32'h1, 2'h0, OK);
        cmd_disable_voltage = 1'b1;
        @(negedge clk_sys);
        cmd_disable_voltage = 1'b0;
        repeat (6) @(negedge clk_sys);
        check({28'h0, drive_state}, 32'h3);
        cmd_shutdown = 1'b1;
        @(negedge clk_sys);
        cmd_shutdown = 1'b0;
        repeat (2) @(negedge clk_sys);
        check({28'h0, drive_state}, 32'h4);
        acc(1'b1, MODE, 32'h0, 2'h0, OK);
        cmd_disable_voltage = 1'b1;
        repeat (3) @(negedge clk_sys);
        check({28'h0, drive_state}, 32'h3);
        cmd_disable_voltage = 1'b0;
        repeat (3) @(negedge clk_sys);
        check({28'h0, drive_state}, 32'h4);
        // profile parameters owned by channel 1
        profile_active = 1'b1;
        profile_channel = 2'h1;
        repeat (3) begin
            v = $urandom;
            acc(1'b1, CTRL, {16'h0, v[15:0]}, 2'h2, BAD);
            acc(1'b1, CTRL, {16'h0, v[15:0]}, 2'h1, OK);
            acc(1'b1, REFA, {16'h0, ~v[15:0]}, 2'h1, OK);
            acc(1'b1, REFB, v, 2'h1, OK);
            acc(1'b0, REFB, 32'h0, 2'h3, BAD);
            acc(1'b0, CTRL, 32'h0, 2'h1, OK);
            check(rd, {16'h0, v[15:0]});
            acc(1'b0, REFA, 32'h0, 2'h1, OK);
            check(rd, {16'h0, ~v[15:0]});
            check(profile_reference_b, v);
            check({16'h0, profile_mode_control}, {16'h0, v[15:0]});
            check({16'h0, profile_reference_a}, {16'h0, ~v[15:0]});
        end
        profile_active = 1'b0;
        acc(1'b0, REFB, 32'h0, 2'h2, OK);
        check(rd, v);
        // restore from persistent storage, invalid code lands as 0
        {nv_motion_src, nv_status_src, nv_mode, nv_restore} = 10'h1F7;
        @(negedge clk_sys);
        nv_restore = 1'b0;
        acc(1'b0, MOT, 32'h0, 2'h0, OK);
        check(rd, 32'h7);
        acc(1'b0, STAT, 32'h0, 2'h0, OK);
        check(rd, 32'h0);
        acc(1'b0, MODE, 32'h0, 2'h0, OK);
        check(rd, 32'h1);
        end_of_test();
    end
endmodule // tb
